/* File: rtl/brownout_reset_pkg.sv */
// Constants for the brown-out reset and reset-cause control block.
// Assumes a 100 MHz APB clock and one aligned 32-bit word per register.
`default_nettype none
package brownout_reset_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h00; // Reset cause and control
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;  // Sticky event flags, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;    // Interrupt enables
  localparam logic [7:0] ADDR_SEQ_STATUS = 8'h0c;  // Live sequencer state, read only

  // Field positions of the reset cause register
  localparam int BIT_IRQ_PRIORITY = 7;
  localparam int BIT_SOFT_BOR = 6;
  localparam int BIT_RESET_INSTR = 4;
  localparam int BIT_WDT_TIMEOUT = 3;
  localparam int BIT_POWERDOWN = 2;
  localparam int BIT_POWERON = 1;
  localparam int BIT_BROWNOUT = 0;

  // Reset values of the reset cause flags after power-on
  localparam logic RST_IRQ_PRIORITY = 1'b0;
  localparam logic RST_RESET_INSTR = 1'b1;
  localparam logic RST_WDT_TIMEOUT = 1'b1;
  localparam logic RST_POWERDOWN = 1'b1;
  localparam logic RST_POWERON = 1'b0;
  localparam logic RST_BROWNOUT = 1'b0;

  // Interrupt event bits
  localparam int IRQ_BITS = 4;
  localparam int EV_BROWNOUT = 0;  // Brown-out reset entered
  localparam int EV_RECOVERED = 1; // Reset released after recovery
  localparam int EV_WDT = 2;       // Watchdog time-out seen
  localparam int EV_RESET_INSTR = 3; // Reset instruction executed

  // Brown-out enable configuration codes
  localparam logic [1:0] BOR_CFG_OFF = 2'h0;
  localparam logic [1:0] BOR_CFG_SOFT = 2'h1;
  localparam logic [1:0] BOR_CFG_NOSLEEP = 2'h2;
  localparam logic [1:0] BOR_CFG_ALWAYS = 2'h3;

  // Timing
  localparam int CLK_MHZ = 100;                  // pclk rate
  localparam int BOR_MIN_NS = 200;               // Least under-voltage time that must reset
  localparam int BOR_MIN_CYCLES = (BOR_MIN_NS * CLK_MHZ + 999) / 1000; // Rounded up
  localparam int POWERUP_TIMER_US = 65000;                // Power-up timer delay
  localparam int POWERUP_TIMER_CYCLES = POWERUP_TIMER_US * CLK_MHZ; // Default for the top parameter

  // Sequencer states
  typedef enum logic [1:0] {SEQ_RUN, SEQ_BROWNOUT, SEQ_POWERUP_TIMER} seq_state_t;
endpackage : brownout_reset_pkg
`default_nettype wire

/* File: rtl/brownout_reset_status_control.sv */
// Brown-out reset sequencer with reset-cause register and APB slave.
// Assumes all inputs synchronous to pclk; core event inputs are one-cycle pulses;
// the supply detector output is a level, high while the supply is under threshold.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`default_nettype none

// Functional notes
// - Soft mode: soft enable bit gates brown-out
// - Other modes: soft bit ignored, reads zero
// - Soft bit loads the config strap on the first edge after reset
// - Powerdown flag set by power-up/clear, sleep clears
// - Power-on flag zero at power-on until written
// - Brown-out flag cleared on every brown-out/power-on
// - Brown-out active when the mode enables it; hold until recovery
// - Power-up timer extends reset, restarts on brown-out
// - Power-up timer enable independent of brown-out
// - Threshold only from configuration, never software
// - No-sleep mode disables brown-out during sleep
// - Request reference; arm only once it is stable
module brownout_reset_status_control #(
  parameter int POWERUP_TIMER_CYCLES = brownout_reset_pkg::POWERUP_TIMER_CYCLES, // Power-up timer length
  parameter int BOR_MIN_CYCLES = brownout_reset_pkg::BOR_MIN_CYCLES // Under-voltage filter
) (
  input wire logic pclk,
  input wire logic presetn,                   // Power-on reset, async, active low
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] brownout_enable_cfg,     // Configuration field
  input wire logic [1:0] brownout_threshold_cfg,  // Configuration field
  input wire logic config_low_byte_two_strap,     // High when low config bits 2:1 hold 01
  input wire logic powerup_timer_enable,          // Configuration, separate from brown-out
  input wire logic supply_below_threshold,        // Detector level
  input wire logic fixed_voltage_reference_stable, // Reference settled
  input wire logic sleep_active,                  // Core is in sleep
  input wire logic reset_instr_exec,              // Pulse: reset instruction
  input wire logic clear_watchdog_instr,          // Pulse: clear-watchdog instruction
  input wire logic sleep_instr,                   // Pulse: sleep instruction
  input wire logic watchdog_timeout,              // Pulse: watchdog expired
  output logic device_reset_hold,                 // High while the device is kept in reset
  output logic fixed_voltage_reference_request,   // Reference wanted by brown-out
  output logic brownout_detect_arm,               // Detector comparison is live
  output logic [1:0] brownout_voltage_sel,        // Threshold to the detector
  output logic irq_priority_mode,                 // Two-level interrupt priority
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic irq_priority_enable;      // Priority level enable
  logic soft_brownout_enable;     // Stored soft enable
  logic reset_instr_flag;         // Low after reset instruction
  logic watchdog_timeout_flag;    // Low after watchdog time-out
  logic powerdown_flag;           // Low after sleep instruction
  logic poweron_status;           // Low after power-on
  logic brownout_status;          // Low after brown-out or power-on
  logic strap_done;               // Strap caught after reset release
  logic [brownout_reset_pkg::IRQ_BITS-1:0] irq_status; // Sticky events
  logic [brownout_reset_pkg::IRQ_BITS-1:0] irq_mask;   // Enables
  logic [brownout_reset_pkg::IRQ_BITS-1:0] irq_event;  // This cycle's events
  brownout_reset_pkg::seq_state_t seq_state;           // Sequencer state
  logic [31:0] powerup_timer_count;        // Power-up timer count down
  logic [15:0] filter_count;      // Under-voltage persistence
  logic brownout_active;          // Brown-out wanted in this mode
  logic under_voltage;            // Filtered detector result
  logic wr_access;                // Write taking effect this edge
  logic setup_phase;              // First cycle of a transfer
  logic addr_hit;                 // Offset decodes to a register
  logic [7:0] cause_read;         // Read view of the cause register
  logic soft_mode;                // Soft enable mode selected
  logic enter_brownout;           // Sequencer goes into brown-out
  logic leave_reset;              // Sequencer releases reset

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite && !pslverr;
  assign pready = 1'b1; // Read data is ready by the access phase
  assign soft_mode = (brownout_enable_cfg == brownout_reset_pkg::BOR_CFG_SOFT);

  // Word offsets only; anything else is an error
  always_comb begin
    addr_hit = 1'b0;
    if (paddr[31:8] == 24'h000000) begin
      case (paddr[7:0])
        brownout_reset_pkg::ADDR_RESET_CAUSE,
        brownout_reset_pkg::ADDR_IRQ_STATUS,
        brownout_reset_pkg::ADDR_IRQ_MASK,
        brownout_reset_pkg::ADDR_SEQ_STATUS: addr_hit = 1'b1;
        default: addr_hit = 1'b0;
      endcase
    end
  end

  // Cause register read view; soft bit hidden outside soft mode
  always_comb begin
    cause_read = 8'h00;
    cause_read[brownout_reset_pkg::BIT_IRQ_PRIORITY] = irq_priority_enable;
    cause_read[brownout_reset_pkg::BIT_SOFT_BOR] = soft_brownout_enable && soft_mode;
    cause_read[brownout_reset_pkg::BIT_RESET_INSTR] = reset_instr_flag;
    cause_read[brownout_reset_pkg::BIT_WDT_TIMEOUT] = watchdog_timeout_flag;
    cause_read[brownout_reset_pkg::BIT_POWERDOWN] = powerdown_flag;
    cause_read[brownout_reset_pkg::BIT_POWERON] = poweron_status;
    cause_read[brownout_reset_pkg::BIT_BROWNOUT] = brownout_status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and error, captured in the setup cycle so both come from flops.
  // A flag that changes between setup and access shows on the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= !addr_hit;
      prdata <= 32'h00000000;
      if (!pwrite) begin
        case (paddr[7:0])
          brownout_reset_pkg::ADDR_RESET_CAUSE: prdata <= {24'h000000, cause_read};
          brownout_reset_pkg::ADDR_IRQ_STATUS: prdata <= {28'h0000000, irq_status};
          brownout_reset_pkg::ADDR_IRQ_MASK: prdata <= {28'h0000000, irq_mask};
          brownout_reset_pkg::ADDR_SEQ_STATUS:
            prdata <= {26'h0000000, brownout_detect_arm, brownout_active, device_reset_hold,
                       seq_state == brownout_reset_pkg::SEQ_POWERUP_TIMER, brownout_voltage_sel};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt priority enable, plain software bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_priority_enable <= brownout_reset_pkg::RST_IRQ_PRIORITY;
    end else if (wr_access && paddr[7:0] == brownout_reset_pkg::ADDR_RESET_CAUSE) begin
      irq_priority_enable <= pwdata[brownout_reset_pkg::BIT_IRQ_PRIORITY];
    end
  end
  assign irq_priority_mode = irq_priority_enable;

  // Soft enable: strap value loaded on the first edge after release,
  // since an async reset may only load a constant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done <= 1'b0;
      soft_brownout_enable <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      soft_brownout_enable <= config_low_byte_two_strap;
    end else if (wr_access && soft_mode && paddr[7:0] == brownout_reset_pkg::ADDR_RESET_CAUSE) begin
      soft_brownout_enable <= pwdata[brownout_reset_pkg::BIT_SOFT_BOR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset instruction flag; the instruction wins over a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_instr_flag <= brownout_reset_pkg::RST_RESET_INSTR;
    end else if (reset_instr_exec) begin
      reset_instr_flag <= 1'b0;
    end else if (wr_access && paddr[7:0] == brownout_reset_pkg::ADDR_RESET_CAUSE) begin
      reset_instr_flag <= pwdata[brownout_reset_pkg::BIT_RESET_INSTR];
    end
  end

  // Watchdog flag; a time-out beats a same-cycle clear or sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_timeout_flag <= brownout_reset_pkg::RST_WDT_TIMEOUT;
    end else if (watchdog_timeout) begin
      watchdog_timeout_flag <= 1'b0;
    end else if (clear_watchdog_instr || sleep_instr) begin
      watchdog_timeout_flag <= 1'b1;
    end
  end

  // Power-down flag; sleep beats a same-cycle clear-watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_flag <= brownout_reset_pkg::RST_POWERDOWN;
    end else if (sleep_instr) begin
      powerdown_flag <= 1'b0;
    end else if (clear_watchdog_instr) begin
      powerdown_flag <= 1'b1;
    end
  end

  // Power-on flag: zero from power-on until firmware writes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poweron_status <= brownout_reset_pkg::RST_POWERON;
    end else if (wr_access && paddr[7:0] == brownout_reset_pkg::ADDR_RESET_CAUSE) begin
      poweron_status <= pwdata[brownout_reset_pkg::BIT_POWERON];
    end
  end

  // Brown-out flag: hardware clear on brown-out beats a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_status <= brownout_reset_pkg::RST_BROWNOUT;
    end else if (enter_brownout) begin
      brownout_status <= 1'b0;
    end else if (wr_access && paddr[7:0] == brownout_reset_pkg::ADDR_RESET_CAUSE) begin
      brownout_status <= pwdata[brownout_reset_pkg::BIT_BROWNOUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode: is brown-out protection wanted right now
  always_comb begin
    case (brownout_enable_cfg)
      brownout_reset_pkg::BOR_CFG_SOFT: brownout_active = soft_brownout_enable && strap_done;
      brownout_reset_pkg::BOR_CFG_NOSLEEP: brownout_active = !sleep_active;
      brownout_reset_pkg::BOR_CFG_ALWAYS: brownout_active = 1'b1;
      default: brownout_active = 1'b0;
    endcase
  end

  // Reference requested whenever protection is wanted; detection waits for it
  assign fixed_voltage_reference_request = brownout_active;
  assign brownout_detect_arm = brownout_active && fixed_voltage_reference_stable;

  // Threshold registered from configuration; no bus path reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_voltage_sel <= 2'h0;
    end else begin
      brownout_voltage_sel <= brownout_threshold_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Under-voltage filter: short dips are ignored, which trades response time
  // for immunity to supply noise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_count <= 16'h0000;
    end else if (!brownout_detect_arm || !supply_below_threshold) begin
      filter_count <= 16'h0000;
    end else if (!under_voltage) begin
      filter_count <= filter_count + 16'h0001;
    end
  end
  assign under_voltage = (filter_count >= 16'(BOR_MIN_CYCLES - 1)) && supply_below_threshold;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: run, held in brown-out, then optional power-up delay
  assign enter_brownout = under_voltage && brownout_detect_arm &&
                          (seq_state != brownout_reset_pkg::SEQ_BROWNOUT);
  assign leave_reset = ((seq_state == brownout_reset_pkg::SEQ_BROWNOUT) && !supply_below_threshold &&
                        !powerup_timer_enable) ||
                       ((seq_state == brownout_reset_pkg::SEQ_POWERUP_TIMER) && powerup_timer_count == 32'h00000000 &&
                        !enter_brownout);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state <= brownout_reset_pkg::SEQ_RUN;
    end else begin
      case (seq_state)
        brownout_reset_pkg::SEQ_RUN: begin
          if (enter_brownout) begin
            seq_state <= brownout_reset_pkg::SEQ_BROWNOUT;
          end
        end
        brownout_reset_pkg::SEQ_BROWNOUT: begin
          // Held until the detector reports recovery
          if (!supply_below_threshold) begin
            if (powerup_timer_enable) begin
              seq_state <= brownout_reset_pkg::SEQ_POWERUP_TIMER;
            end else begin
              seq_state <= brownout_reset_pkg::SEQ_RUN;
            end
          end
        end
        brownout_reset_pkg::SEQ_POWERUP_TIMER: begin
          if (enter_brownout) begin
            seq_state <= brownout_reset_pkg::SEQ_BROWNOUT;
          end else if (powerup_timer_count == 32'h00000000) begin
            seq_state <= brownout_reset_pkg::SEQ_RUN;
          end
        end
        default: seq_state <= brownout_reset_pkg::SEQ_RUN;
      endcase
    end
  end

  // Power-up timer: reloaded while in brown-out, counts only in its state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerup_timer_count <= 32'h00000000;
    end else if (seq_state != brownout_reset_pkg::SEQ_POWERUP_TIMER || enter_brownout) begin
      powerup_timer_count <= 32'(POWERUP_TIMER_CYCLES - 1);
    end else if (powerup_timer_count != 32'h00000000) begin
      powerup_timer_count <= powerup_timer_count - 32'h00000001;
    end
  end

  assign device_reset_hold = (seq_state != brownout_reset_pkg::SEQ_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events: one generate loop of sticky bits, set beats clear
  assign irq_event[brownout_reset_pkg::EV_BROWNOUT] = enter_brownout;
  assign irq_event[brownout_reset_pkg::EV_RECOVERED] = leave_reset;
  assign irq_event[brownout_reset_pkg::EV_WDT] = watchdog_timeout;
  assign irq_event[brownout_reset_pkg::EV_RESET_INSTR] = reset_instr_exec;

  for (genvar i = 0; i < brownout_reset_pkg::IRQ_BITS; i++) begin : g_irq
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_status[i] <= 1'b0;
      end else if (irq_event[i]) begin
        irq_status[i] <= 1'b1;
      end else if (wr_access && paddr[7:0] == brownout_reset_pkg::ADDR_IRQ_STATUS && pwdata[i]) begin
        irq_status[i] <= 1'b0;
      end
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= 4'h0;
    end else if (wr_access && paddr[7:0] == brownout_reset_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= pwdata[brownout_reset_pkg::IRQ_BITS-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule : brownout_reset_status_control
`default_nettype wire

/* File: bench/brownout_reset_asserts.sv */
// Checker: port timing of the brown-out reset block.
// Assumes a bind into the design top; one pclk domain.
`default_nettype none
module brownout_reset_asserts #(
  parameter int POWERUP_TIMER_CYCLES = 8,
  parameter int BOR_MIN_CYCLES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0] brownout_enable_cfg,
  input wire logic [1:0] brownout_threshold_cfg,
  input wire logic powerup_timer_enable,
  input wire logic supply_below_threshold,
  input wire logic fixed_voltage_reference_stable,
  input wire logic sleep_active,
  input wire logic device_reset_hold,
  input wire logic fixed_voltage_reference_request,
  input wire logic brownout_detect_arm,
  input wire logic [1:0] brownout_voltage_sel,
  input wire logic irq_priority_mode
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire hold = device_reset_hold; // Short aliases
  wire low = supply_below_threshold;
  wire req = fixed_voltage_reference_request;
  wire [1:0] cfg = brownout_enable_cfg;
  int unsigned low_cnt; // Armed under-voltage cycles so far
  int unsigned rel_cnt; // Held cycles since the supply recovered
  ////////////////////////////////////////////////////////////////
  // Counters; a glitch shorter than the filter restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 0;
      rel_cnt <= 0;
    end else begin
      low_cnt <= (brownout_detect_arm && low && !hold) ? low_cnt + 1 : 0;
      rel_cnt <= (hold && !low) ? rel_cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_PRIO: assert property (psel && penable && pwrite && paddr == 32'h0 |=> irq_priority_mode == $past(pwdata[7]))
    else $error("priority mode missed a write");
  AST_OFF: assert property (cfg == 2'h0 |-> !req)
    else $error("reference requested with brown-out off");
  AST_ALWAYS: assert property (cfg == 2'h3 |-> req)
    else $error("brown-out dropped in always mode");
  AST_NOSLEEP: assert property (cfg == 2'h2 |-> req == !sleep_active)
    else $error("sleep gating wrong");
  AST_ARM: assert property (brownout_detect_arm == (req && fixed_voltage_reference_stable))
    else $error("arm not tied to stable reference");
  AST_VSEL: assert property (1'b1 |=> brownout_voltage_sel == $past(brownout_threshold_cfg))
    else $error("threshold not from configuration");
  AST_ENTER: assert property (!hold && brownout_detect_arm && low && low_cnt == BOR_MIN_CYCLES - 1 |=> hold)
    else $error("filtered under-voltage gave no reset");
  AST_STAY: assert property (hold && low |=> hold)
    else $error("reset released while under voltage");
  AST_NOTIMER: assert property (hold && !low && !powerup_timer_enable |=> !hold)
    else $error("reset extended with timer off");
  AST_TIMER: assert property (hold && powerup_timer_enable && rel_cnt < POWERUP_TIMER_CYCLES |=> hold)
    else $error("power-up delay cut short");
  AST_TIMER_END: assert property (hold |-> rel_cnt <= POWERUP_TIMER_CYCLES + 1)
    else $error("power-up delay too long");
  COV_ENTER: cover property ($rose(hold));
  COV_TIMER: cover property (hold && !low && powerup_timer_enable);
  COV_SLEEP: cover property (cfg == 2'h2 && sleep_active);
endmodule : brownout_reset_asserts
bind brownout_reset_status_control brownout_reset_asserts #(
  .POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES), .BOR_MIN_CYCLES(BOR_MIN_CYCLES)) brownout_reset_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .brownout_enable_cfg(brownout_enable_cfg), .brownout_threshold_cfg(brownout_threshold_cfg),
  .powerup_timer_enable(powerup_timer_enable), .supply_below_threshold(supply_below_threshold),
  .fixed_voltage_reference_stable(fixed_voltage_reference_stable), .sleep_active(sleep_active),
  .device_reset_hold(device_reset_hold), .fixed_voltage_reference_request(fixed_voltage_reference_request),
  .brownout_detect_arm(brownout_detect_arm), .brownout_voltage_sel(brownout_voltage_sel),
  .irq_priority_mode(irq_priority_mode));
`default_nettype wire

/* File: bench/brownout_reset_status_control_tb.sv */
// Bench: APB-driven checks of the brown-out block against a model.
// Assumes package, design and bound checker compiled before it.
`default_nettype none
module brownout_reset_status_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POWERUP_TIMER = 8; // Short timer keeps the run brief
  localparam int BMIN = 2; // Under-voltage filter length
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [1:0] bcfg, vcfg, vsel;
  logic strap, powerup_timer_en, below, ref_ok, slp, hold, req, arm, prio, irq;
  logic [3:0] ev; // Pulses: reset instr, clear watchdog, sleep, timeout
  int m_cause, m_st, m_mask, fail_count, checks_done, n; // Model and counters
  brownout_reset_status_control #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER), .BOR_MIN_CYCLES(BMIN)) brownout_reset_status_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .brownout_enable_cfg(bcfg),
    .brownout_threshold_cfg(vcfg), .config_low_byte_two_strap(strap), .powerup_timer_enable(powerup_timer_en),
    .supply_below_threshold(below), .fixed_voltage_reference_stable(ref_ok), .sleep_active(slp),
    .reset_instr_exec(ev[0]), .clear_watchdog_instr(ev[1]), .sleep_instr(ev[2]), .watchdog_timeout(ev[3]),
    .device_reset_hold(hold), .fixed_voltage_reference_request(req), .brownout_detect_arm(arm),
    .brownout_voltage_sel(vsel), .irq_priority_mode(prio), .irq(irq));
  ////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; idle edge first so strobes never change twice at once
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int w;
    @(posedge pclk);
    {psel, penable, pwrite} <= {1'b1, 1'b0, wr};
    {paddr, pwdata} <= {a, d};
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    if (w == 20) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Cause write; bits 3 and 2 read only, bit 6 only in soft mode
  task automatic wrc(input int d);
    m_cause = (m_cause & 32'h0c) | (d & (bcfg == 2'h1 ? 32'hd3 : 32'h93));
    apb(1'b1, brownout_reset_pkg::ADDR_RESET_CAUSE, d);
  endtask : wrc
  task automatic rdc();
    apb(1'b0, brownout_reset_pkg::ADDR_RESET_CAUSE, 32'h0);
    chk("cause", m_cause & (bcfg == 2'h1 ? 32'hff : 32'hbf), rd);
  endtask : rdc
  // Core event pulse, one cycle
  task automatic pulse(input int k);
    @(posedge pclk);
    ev <= 4'h1 << k;
    @(posedge pclk);
    ev <= 4'h0;
    case (k)
      0: {m_cause, m_st} = {m_cause & ~32'h10, m_st | 32'h8};
      1: m_cause = m_cause | 32'h0c;
      2: m_cause = (m_cause | 32'h08) & ~32'h04;
      default: {m_cause, m_st} = {m_cause & ~32'h08, m_st | 32'h4};
    endcase
  endtask : pulse
  // Edges until hold shows v, sampled mid-cycle, then realigned
  task automatic edges(input logic v);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      @(negedge pclk);
    end while (hold !== v && n < 100);
    if (n == 100) begin
      fail_count++;
      summarize();
    end
    @(posedge pclk);
  endtask : edges
  task automatic irqc();
    @(negedge pclk);
    chk("irq", |(m_st & m_mask), irq);
  endtask : irqc
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, powerup_timer_en, below, slp, ev, presetn} = '0;
    {paddr, pwdata, vcfg, bcfg, strap, ref_ok} = {64'h0, 2'h0, 2'h1, 2'b11};
    {fail_count, checks_done, m_st, m_mask} = '0;
    n = $urandom(32'hbed7cf2a);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    m_cause = 32'h5c;
    rdc();
    apb(1'b0, brownout_reset_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("status", 0, rd);
    apb(1'b1, 32'h10, 32'hff);
    chk("pslverr", 1, err);
    for (int i = 0; i < 6; i++) begin
      wrc($urandom);
      rdc();
      @(negedge pclk);
      chk("prio", m_cause[7], prio);
      chk("arm", m_cause[6], arm);
    end
    wrc(32'h40);
    @(posedge pclk);
    ref_ok <= 1'b0;
    @(negedge pclk);
    chk("arm", 0, arm);
    @(posedge pclk);
    ref_ok <= 1'b1;
    apb(1'b1, brownout_reset_pkg::ADDR_IRQ_MASK, 32'h1);
    m_mask = 1;
    for (int i = 0; i < 8; i++) begin
      pulse(i < 4 ? i : $urandom % 4);
      rdc();
    end
    apb(1'b0, brownout_reset_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("status", m_st, rd);
    irqc();
    for (int c = 0; c < 8; c++) begin
      @(posedge pclk);
      bcfg <= 2'((c / 2 + 1) % 4);
      slp <= c[0];
      vcfg <= 2'($urandom);
      @(posedge pclk);
      @(negedge pclk);
      chk("vsel", vcfg, vsel);
      chk("req", bcfg == 2'h0 ? 0 : bcfg == 2'h1 ? m_cause[6] : bcfg == 2'h2 ? !slp : 1, req);
      wrc(32'h40);
      rdc();
    end
    @(posedge pclk);
    {bcfg, slp} <= {2'h3, 1'b0};
    wrc(32'h13);
    for (int t = 0; t < 2; t++) begin
      powerup_timer_en <= t[0];
      below <= 1'b1;
      edges(1'b1);
      chk("rise", BMIN, n);
      {m_cause, m_st} = {m_cause & ~32'h1, m_st | 32'h1};
      repeat (3) @(posedge pclk);
      below <= 1'b0;
      if (t == 1) begin
        repeat (4) @(posedge pclk);
        below <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("held", 1, hold);
        below <= 1'b0;
      end
      edges(1'b0);
      chk("release", t == 1 ? POWERUP_TIMER + 1 : 1, n);
      m_st = m_st | 32'h2;
    end
    rdc();
    apb(1'b0, brownout_reset_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("status", m_st, rd);
    irqc();
    apb(1'b1, brownout_reset_pkg::ADDR_IRQ_STATUS, m_st);
    m_st = 0;
    irqc();
    // Live state is read only: a write must not move the threshold
    apb(1'b1, brownout_reset_pkg::ADDR_SEQ_STATUS, 32'hff);
    apb(1'b0, brownout_reset_pkg::ADDR_SEQ_STATUS, 32'h0);
    chk("seq", 32'h30 | vcfg, rd);
    apb(1'b0, brownout_reset_pkg::ADDR_IRQ_MASK, 32'h0);
    chk("mask", m_mask, rd);
    summarize();
  end
endmodule : brownout_reset_status_control_tb
`default_nettype wire
